// ---- hw/ttymx_defs.vh ----
/*
  shared constants of the teletype multiplexer channel port: function codes,
  word field positions, status bits and service timing.
  assumes inclusion by bare name from design and bench files.
*/
`ifndef TTYMX_DEFS_VH
`define TTYMX_DEFS_VH

// function code fields
`define TTYMX_EQ_HI        11
`define TTYMX_EQ_LO        9
`define TTYMX_FN_OUTPUT    9'h001
`define TTYMX_FN_STATUS    9'h002
`define TTYMX_FN_INPUT     9'h003

// output word control field
`define TTYMX_OUT_REQ_BIT  11
`define TTYMX_OUT_DISC_BIT 10

// input word flag bits
`define TTYMX_IN_REJ_BIT   8
`define TTYMX_IN_RDY_BIT   9
`define TTYMX_IN_LOST_BIT  10
`define TTYMX_IN_VALID_BIT 11

// status word bits
`define TTYMX_ST_SVCFAIL   0
`define TTYMX_ST_INREQ     1
`define TTYMX_ST_CHANA     2

// service timing
`define TTYMX_CLK_MHZ      250
`define TTYMX_CHAR_MS_110  100
`define TTYMX_CHAR_CYC_110 (`TTYMX_CHAR_MS_110 * 1000 * `TTYMX_CLK_MHZ)
`define TTYMX_BAUD_600     600
`define TTYMX_BITS_CHAR    11
// scaled by 100 on both sides so the product stays inside 32-bit integer range
`define TTYMX_CHAR_CYC_600 ((`TTYMX_BITS_CHAR * 10000 * `TTYMX_CLK_MHZ) / (`TTYMX_BAUD_600 / 100))
`define TTYMX_REQ_PCT      95
`define TTYMX_LOST_MS      5
`define TTYMX_LOST_CYC     (`TTYMX_LOST_MS * 1000 * `TTYMX_CLK_MHZ)

`endif

// ---- hw/ttymx_channel_port.v ----
/*
  channel front end of a 64-terminal teletype multiplexer: function decode,
  inactive/active handshake, output and input blocks, status word, per-terminal
  flag and buffer store, service timing, duplex/baud/stop configuration.
  assumes a synchronous host channel on core_clk_in and a serial bit engine
  outside that drains the output buffer and fills the input buffer per terminal.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ttymx_defs.vh"

module ttymx_channel_port #(
  parameter        NTERM      = 64,
  parameter [31:0] CHAR_110   = `TTYMX_CHAR_CYC_110,
  parameter [31:0] CHAR_600   = `TTYMX_CHAR_CYC_600,
  parameter [31:0] LOST_CYC   = `TTYMX_LOST_CYC
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        master_clear_in,
  input  wire [2:0]  equip_sw_in,
  input  wire        mixed_duplex_in,
  input  wire [5:0]  first_full_sw_in,
  input  wire        mixed_baud_in,
  input  wire [5:0]  first_110_sw_in,
  input  wire        stop_one_in,
  input  wire        svc_600_in,
  input  wire        func_in,
  input  wire [11:0] chan_data_in,
  input  wire        chan_full_in,
  input  wire        chan_active_in,
  input  wire        chan_disc_in,
  output wire        chan_inactive_out,
  output wire        chan_empty_out,
  output wire [11:0] chan_data_out,
  input  wire        chan_ready_in,
  output reg  [2:0]  mode_out,
  output wire [2:0]  status_out,
  output wire        tx_valid_out,
  output wire [5:0]  tx_term_out,
  output wire [7:0]  tx_char_out,
  output wire        tx_full_duplex_out,
  output wire        tx_baud_110_out,
  output wire        tx_stop_two_out,
  input  wire        tx_take_in,
  output reg  [5:0]  disc_term_out,
  output reg         disc_valid_out,
  input  wire        rx_valid_in,
  input  wire [5:0]  rx_term_in,
  input  wire [7:0]  rx_char_in,
  input  wire [NTERM-1:0] interlock_in
);

  localparam [2:0] MD_IDLE = 3'h0;
  localparam [2:0] MD_OUT  = 3'h1;
  localparam [2:0] MD_STAT = 3'h2;
  localparam [2:0] MD_IN   = 3'h3;
  localparam [1:0] PH_ARM  = 2'h0;
  localparam [1:0] PH_RUN  = 2'h1;
  localparam [1:0] PH_DONE = 2'h2;

  // clear comes from a switch: three-stage synchroniser, act when 2 and 3 agree
  // the clear is held off while the last two stages disagree, so a one-cycle
  // bounce cannot chop the clear into fragments; reset also empties the chain
  // so a clear held through reset still acts once reset ends
  reg [2:0] mclr_sync_ff;
  reg       mclr_ff;
  wire      clr = rst_in | mclr_ff;
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      mclr_sync_ff <= 3'h0;
      mclr_ff      <= 1'b0;
    end else begin
      mclr_sync_ff <= {mclr_sync_ff[1:0], master_clear_in};
      if (mclr_sync_ff[1] == mclr_sync_ff[2])
        mclr_ff <= mclr_sync_ff[2];
    end
  end

  // per-terminal store
  // one entry per terminal, addressed by terminal number; output and input
  // halves are independent so a terminal can send and receive at once
  // conn_ff drops on a disconnect word and recovers when interlock falls
  reg [7:0]       obuf_ff [0:NTERM-1];
  reg [NTERM-1:0] ofull_ff;
  reg [7:0]       ibuf_ff [0:NTERM-1];
  reg [NTERM-1:0] ivalid_ff;
  reg [NTERM-1:0] rej_ff;
  reg [NTERM-1:0] lost_ff;
  reg [NTERM-1:0] conn_ff;

  reg [1:0]  phase_ff;
  reg [5:0]  widx_ff;
  reg        inact_ff;
  reg        svcfail_ff;
  reg        inreq_ff;
  reg        lostwin_ff;
  reg [31:0] tmr_ff;
  reg [31:0] lwin_ff;
  reg [5:0]  scan_ff;

  // function decode
  // a code counts only in the cycle of the function strobe; the equipment
  // field and the mode field must both be good, anything else leaves the
  // sequencer and the handshake untouched
  wire eq_hit = func_in && (chan_data_in[`TTYMX_EQ_HI:`TTYMX_EQ_LO] == equip_sw_in);
  wire [8:0] fcode = chan_data_in[8:0];
  wire fn_ok = (fcode == `TTYMX_FN_OUTPUT) || (fcode == `TTYMX_FN_STATUS) ||
               (fcode == `TTYMX_FN_INPUT);

  assign chan_inactive_out = inact_ff;
  assign status_out = {1'b1, inreq_ff, svcfail_ff};

  // two-entry skid buffer on the channel read path
  // words are written at the tail and read at entry 0, so chan_data_out is
  // a flop; a host stall fills the second entry and then holds the source
  // back, and no word is dropped or sent twice
  reg  [11:0] sk_data_ff [0:1];
  reg  [1:0]  sk_cnt_ff;
  reg         sk_rd_ff;
  wire        sk_push;
  wire        sk_pop = chan_ready_in && (sk_cnt_ff != 2'h0);
  wire        sk_room = (sk_cnt_ff != 2'h2);
  assign chan_empty_out = (sk_cnt_ff == 2'h0);
  assign chan_data_out  = sk_data_ff[0];

  // word produced for the channel in input or status mode
  // the word for terminal t is taken at push time; flags cleared by the push
  // become visible only in the next block
  wire [5:0] t = widx_ff;
  wire [11:0] in_word = {ivalid_ff[t], lost_ff[t], conn_ff[t] & interlock_in[t], rej_ff[t],
                         ibuf_ff[t]};
  wire [11:0] st_word = {9'h000, status_out};
  assign sk_push = sk_room && chan_active_in && phase_ff == PH_RUN &&
                   (mode_out == MD_IN || mode_out == MD_STAT);
  wire in_send = sk_push && mode_out == MD_IN;

  // output word decode
  // words arrive only while running in output mode; the block counter
  // gives each word its terminal, so word n always reaches terminal n
  wire ow_take = chan_full_in && chan_active_in && phase_ff == PH_RUN && mode_out == MD_OUT;
  wire ow_req  = chan_data_in[`TTYMX_OUT_REQ_BIT];
  wire ow_disc = ow_req && chan_data_in[`TTYMX_OUT_DISC_BIT];

  always @(posedge core_clk_in) begin
    if (clr) begin
      sk_cnt_ff     <= 2'h0;
      sk_data_ff[0] <= 12'h000;
      sk_data_ff[1] <= 12'h000;
    end else begin
      case ({sk_push, sk_pop})
        2'b10: begin
          sk_data_ff[sk_cnt_ff[0]] <= sk_push ? (mode_out == MD_IN ? in_word : st_word) : 12'h000;
          sk_cnt_ff <= sk_cnt_ff + 2'h1;
        end
        2'b01: begin
          sk_data_ff[0] <= sk_data_ff[1];
          sk_cnt_ff <= sk_cnt_ff - 2'h1;
        end
        2'b11: begin
          if (sk_cnt_ff == 2'h1)
            sk_data_ff[0] <= (mode_out == MD_IN) ? in_word : st_word;
          else begin
            sk_data_ff[0] <= sk_data_ff[1];
            sk_data_ff[1] <= (mode_out == MD_IN) ? in_word : st_word;
          end
        end
        default: sk_cnt_ff <= sk_cnt_ff;
      endcase
    end
  end

  // mode / handshake sequencer
  // a new function always restarts the block at word 0, even in mid-block;
  // disconnect drops the mode, and a finished block waits in the done phase
  // so extra words or active cycles change nothing
  always @(posedge core_clk_in) begin
    if (clr) begin
      mode_out <= MD_IDLE;
      phase_ff <= PH_ARM;
      widx_ff  <= 6'h00;
      inact_ff <= 1'b0;
    end else begin
      inact_ff <= 1'b0;
      if (eq_hit && fn_ok) begin
        mode_out <= fcode[2:0];
        phase_ff <= PH_ARM;
        widx_ff  <= 6'h00;
        inact_ff <= 1'b1;
      end else if (chan_disc_in) begin
        mode_out <= MD_IDLE;
        phase_ff <= PH_ARM;
      end else begin
        case (phase_ff)
          PH_ARM:  if (chan_active_in && mode_out != MD_IDLE) phase_ff <= PH_RUN;
          PH_RUN: begin
            if (ow_take || sk_push) begin
              widx_ff <= widx_ff + 6'h01;
              if (mode_out == MD_STAT || widx_ff == NTERM[5:0] - 6'h01)
                phase_ff <= PH_DONE;
            end
          end
          PH_DONE: phase_ff <= PH_DONE;
          default: phase_ff <= PH_ARM;
        endcase
      end
    end
  end

  // terminal configuration of the word at the head of the transmit scan
  wire tx_hit = ofull_ff[scan_ff];
  assign tx_valid_out       = tx_hit;
  assign tx_term_out        = scan_ff;
  assign tx_char_out        = obuf_ff[scan_ff];
  assign tx_full_duplex_out = mixed_duplex_in && (scan_ff >= first_full_sw_in);
  assign tx_baud_110_out    = mixed_baud_in && (scan_ff >= first_110_sw_in);
  assign tx_stop_two_out    = tx_baud_110_out || !stop_one_in;

  // scan advances independently of channel mode
  // the scan stops on a terminal with a waiting character until the serial
  // engine takes it; the channel never stalls it
  always @(posedge core_clk_in) begin
    if (clr)
      scan_ff <= 6'h00;
    else if (!tx_hit || tx_take_in)
      scan_ff <= scan_ff + 6'h01;
  end

  // per-terminal buffers and flags; events set over clears
  // a set and a clear of one flag in the same cycle leave it set, except conn_ff, where the disconnect word's clear wins: the later
  // assignment wins, and events are written after the transfer clears
  // so a character that arrives while its word is sent is not lost
  integer i;
  always @(posedge core_clk_in) begin
    if (clr) begin
      ofull_ff  <= {NTERM{1'b0}};
      ivalid_ff <= {NTERM{1'b0}};
      rej_ff    <= {NTERM{1'b0}};
      lost_ff   <= {NTERM{1'b0}};
      conn_ff   <= {NTERM{1'b1}};
      disc_valid_out <= 1'b0;
      disc_term_out  <= 6'h00;
      for (i = 0; i < NTERM; i = i + 1) begin
        obuf_ff[i] <= 8'h00;
        ibuf_ff[i] <= 8'h00;
      end
    end else begin
      disc_valid_out <= 1'b0;
      if (tx_hit && tx_take_in)
        ofull_ff[scan_ff] <= 1'b0;
      if (in_send) begin
        rej_ff[t]    <= 1'b0;
        lost_ff[t]   <= 1'b0;
        ivalid_ff[t] <= 1'b0;
      end
      for (i = 0; i < NTERM; i = i + 1)
        if (!interlock_in[i])
          conn_ff[i] <= 1'b1;
      if (ow_take && ow_req) begin
        if (ow_disc) begin
          conn_ff[widx_ff] <= 1'b0;
          disc_valid_out   <= 1'b1;
          disc_term_out    <= widx_ff;
        end else if (ofull_ff[widx_ff] && !(tx_hit && tx_take_in && scan_ff == widx_ff))
          rej_ff[widx_ff] <= 1'b1;
        else begin
          obuf_ff[widx_ff]  <= chan_data_in[7:0];
          ofull_ff[widx_ff] <= 1'b1;
        end
      end
      if (rx_valid_in && conn_ff[rx_term_in] && interlock_in[rx_term_in]) begin
        ibuf_ff[rx_term_in]   <= rx_char_in;
        ivalid_ff[rx_term_in] <= 1'b1;
        if (ivalid_ff[rx_term_in] && !(in_send && t == rx_term_in))
          lost_ff[rx_term_in] <= 1'b1;
      end
      if (lostwin_ff && ivalid_ff[t] && lwin_ff == LOST_CYC - 32'h1)
        lost_ff[t] <= 1'b1;
    end
  end

  // service clock: input required at 95 percent of a character time
  // the timer runs free from reset; select input clears both status flags
  // except where the clock sets them in that same cycle, and the set wins
  // the loss window opens at input required and lasts LOST_CYC cycles
  wire [31:0] char_cyc = svc_600_in ? CHAR_600 : CHAR_110;
  wire [31:0] req_cyc  = (char_cyc / 32'd100) * `TTYMX_REQ_PCT;
  wire        sel_in   = eq_hit && fcode == `TTYMX_FN_INPUT;
  always @(posedge core_clk_in) begin
    if (clr) begin
      tmr_ff     <= 32'h0;
      lwin_ff    <= 32'h0;
      inreq_ff   <= 1'b0;
      svcfail_ff <= 1'b0;
      lostwin_ff <= 1'b0;
    end else begin
      tmr_ff <= (tmr_ff >= char_cyc - 32'h1) ? 32'h0 : tmr_ff + 32'h1;
      if (tmr_ff == req_cyc - 32'h1) begin
        inreq_ff   <= 1'b1;
        lostwin_ff <= 1'b1;
        lwin_ff    <= 32'h0;
      end else if (lostwin_ff) begin
        lwin_ff <= lwin_ff + 32'h1;
        if (lwin_ff >= LOST_CYC - 32'h1)
          lostwin_ff <= 1'b0;
      end
      if (inreq_ff && tmr_ff == char_cyc - 32'h1)
        svcfail_ff <= 1'b1;
      else if (sel_in)
        svcfail_ff <= 1'b0;
      if (sel_in && !(tmr_ff == req_cyc - 32'h1))
        inreq_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- verif/ttymx_host.sv ----
/* host processor model on the 12-bit channel: function, active, words.
   assumes calls just after a rising edge of core_clk_in. */
`timescale 1ns/1ps
`default_nettype none
module ttymx_host (
  input  wire logic        core_clk_in,
  input  wire logic        inactive_in,
  input  wire logic        empty_in,
  input  wire logic [11:0] data_in,
  output var  logic        func_out   = 1'b0,
  output var  logic [11:0] data_out   = 12'h000,
  output var  logic        full_out   = 1'b0,
  output var  logic        active_out = 1'b0,
  output var  logic        disc_out   = 1'b0,
  output var  logic        ready_out  = 1'b0
);
  int n = 0;
  // one-cycle function strobe, answer read one edge later
  task automatic select(input logic [11:0] code, output logic ok);
    func_out <= 1'b1;
    data_out <= code;
    @(posedge core_clk_in);
    func_out <= 1'b0;
    data_out <= ~code; // released lines do not keep the code
    @(posedge core_clk_in);
    ok = inactive_in;
  endtask
  // active only after inactive was seen
  task automatic go();
    active_out <= 1'b1;
    @(posedge core_clk_in); // device enters run on this edge, words follow
  endtask
  // output word with its strobe
  task automatic push(input logic [11:0] w);
    full_out <= 1'b1;
    data_out <= w;
    @(posedge core_clk_in);
    full_out <= 1'b0;
    data_out <= ~w;
    @(posedge core_clk_in); // gap edge: the next push never rewrites the strobe in one step
  endtask
  // take head word, stalling before every third one
  task automatic pop(output logic [11:0] w);
    if (n % 3 == 2) begin
      ready_out <= 1'b0;
      repeat (2) @(posedge core_clk_in);
    end
    ready_out <= 1'b1;
    w = 12'hfff;
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk_in);
      if (empty_in === 1'b0) begin
        w = data_in;
        break;
      end
    end
    n++;
  endtask
  // drop active and disconnect
  task automatic disc();
    active_out <= 1'b0;
    ready_out  <= 1'b0;
    disc_out   <= 1'b1;
    @(posedge core_clk_in);
    disc_out   <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/ttymx_channel_port_properties.sv ----
/* checker of function handshake, mode and terminal offer flags.
   assumes bind onto the channel port top module. */
`timescale 1ns/1ps
`default_nettype none
module ttymx_chk (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        master_clear_in,
  input wire logic [2:0]  equip_sw_in,
  input wire logic        mixed_duplex_in,
  input wire logic [5:0]  first_full_sw_in,
  input wire logic        mixed_baud_in,
  input wire logic [5:0]  first_110_sw_in,
  input wire logic        stop_one_in,
  input wire logic        func_in,
  input wire logic [11:0] chan_data_in,
  input wire logic        chan_disc_in,
  input wire logic        chan_inactive_out,
  input wire logic [2:0]  mode_out,
  input wire logic [2:0]  status_out,
  input wire logic        tx_valid_out,
  input wire logic [5:0]  tx_term_out,
  input wire logic        tx_full_duplex_out,
  input wire logic        tx_baud_110_out,
  input wire logic        tx_stop_two_out
);
  logic [4:0] mc_ff;
  // recent master clear history masks the checks
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mc_ff <= 5'h00;
    end else begin
      mc_ff <= {mc_ff[3:0], master_clear_in};
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in || master_clear_in || mc_ff != 5'h00);
  a_func_accept: assert property (func_in && chan_data_in[11:9] == equip_sw_in &&
    chan_data_in[8:0] inside {9'h001, 9'h002, 9'h003}
    |=> chan_inactive_out && mode_out == $past(chan_data_in[2:0]))
    else $error("accepted function gave no answer");
  a_func_ignore: assert property (func_in && chan_data_in[11:9] != equip_sw_in
    |=> !chan_inactive_out && $stable(mode_out)) else $error("foreign function answered");
  a_inactive_cause: assert property (chan_inactive_out |-> $past(func_in))
    else $error("inactive without function");
  a_disc_idle: assert property (chan_disc_in |=> mode_out == 3'h0)
    else $error("mode kept after disconnect");
  a_chan_a_set: assert property (status_out[2])
    else $error("channel a bit clear");
  a_duplex_split: assert property (tx_valid_out |-> tx_full_duplex_out ==
    (mixed_duplex_in && tx_term_out >= first_full_sw_in)) else $error("duplex wrong");
  a_baud_split: assert property (tx_valid_out |-> tx_baud_110_out ==
    (mixed_baud_in && tx_term_out >= first_110_sw_in)) else $error("baud wrong");
  a_stop_len: assert property (tx_valid_out |-> tx_stop_two_out ==
    (tx_baud_110_out || !stop_one_in)) else $error("stop length wrong");
endmodule
bind ttymx_channel_port ttymx_chk u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .master_clear_in(master_clear_in), .equip_sw_in(equip_sw_in),
  .mixed_duplex_in(mixed_duplex_in), .first_full_sw_in(first_full_sw_in),
  .mixed_baud_in(mixed_baud_in), .first_110_sw_in(first_110_sw_in),
  .stop_one_in(stop_one_in), .func_in(func_in), .chan_data_in(chan_data_in),
  .chan_disc_in(chan_disc_in), .chan_inactive_out(chan_inactive_out),
  .mode_out(mode_out), .status_out(status_out), .tx_valid_out(tx_valid_out),
  .tx_term_out(tx_term_out), .tx_full_duplex_out(tx_full_duplex_out),
  .tx_baud_110_out(tx_baud_110_out), .tx_stop_two_out(tx_stop_two_out));
`default_nettype wire

// ---- verif/tb.sv ----
/* self-checking bench of the channel port with host model and engine.
   assumes shortened service timing parameters. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, mclr = 1'b0, take = 1'b1, rxv = 1'b0, ok;
  logic [5:0] rxt = 6'h00;
  logic [7:0] rxc = 8'h00;
  logic [63:0] ilk = 64'h0;
  logic func, full, act, dsc, rdy, inact, empty, txv, txfd, txb, txs, dv;
  logic [11:0] din, dout, w, blk [0:63];
  logic [2:0] mode, st;
  logic [5:0] txt, dt;
  logic [7:0] txc;
  logic [13:0] tx_last = 14'h0;
  int tx_cnt = 0, cyc = 0, num_errors = 0, comparisons = 0;
  logic [5:0] disc_last = 6'h3f;
  localparam int CHAR110 = 1000;
  logic [2:0] eq = 3'h5;
  logic mdup = 1'b1, mbaud = 1'b1, stop1 = 1'b1, svc = 1'b1;
  logic [5:0] ffs = 6'h00, f110 = 6'h01;
  ttymx_channel_port #(.CHAR_110(CHAR110), .CHAR_600(200), .LOST_CYC(50)) dut (
    .core_clk_in(clk), .rst_in(rst), .master_clear_in(mclr), .equip_sw_in(eq),
    .mixed_duplex_in(mdup), .first_full_sw_in(ffs), .mixed_baud_in(mbaud),
    .first_110_sw_in(f110), .stop_one_in(stop1), .svc_600_in(svc), .func_in(func),
    .chan_data_in(din), .chan_full_in(full), .chan_active_in(act), .chan_disc_in(dsc),
    .chan_inactive_out(inact), .chan_empty_out(empty), .chan_data_out(dout),
    .chan_ready_in(rdy), .mode_out(mode), .status_out(st), .tx_valid_out(txv),
    .tx_term_out(txt), .tx_char_out(txc), .tx_full_duplex_out(txfd),
    .tx_baud_110_out(txb), .tx_stop_two_out(txs), .tx_take_in(take),
    .disc_term_out(dt), .disc_valid_out(dv), .rx_valid_in(rxv), .rx_term_in(rxt),
    .rx_char_in(rxc), .interlock_in(ilk));
  ttymx_host host (.core_clk_in(clk), .inactive_in(inact), .empty_in(empty),
    .data_in(dout), .func_out(func), .data_out(din), .full_out(full),
    .active_out(act), .disc_out(dsc), .ready_out(rdy));
  initial forever #2 clk = ~clk;
  // serial engine side watcher and run limit
  always @(posedge clk) begin
    if (txv && take) begin
      tx_cnt++;
      tx_last = {txt, txc};
    end
    if (dv) disc_last = dt;
    if (++cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // character into the receive side
  task automatic rx(input logic [5:0] t, input logic [7:0] c);
    rxv <= 1'b1;
    rxt <= t;
    rxc <= c;
    @(posedge clk);
    rxv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_select();
    for (int k = 1; k < 4; k++) begin
      host.select({3'h5, 9'(k)}, ok);
      chk(ok, 1'b1);
      chk(mode, 3'(k));
      host.disc();
    end
    host.select(12'h201, ok);
    chk(ok, 1'b0);
    chk(mode, 3'h0);
    $display("t_select done");
  endtask
  task automatic t_output();
    host.select(12'ha01, ok);
    host.go();
    host.push(12'h8c3);
    host.push(12'h000);
    host.push(12'hc00);
    host.disc();
    repeat (100) @(posedge clk);
    chk(tx_cnt, 1);
    chk(tx_last, {6'h00, 8'hc3});
    chk(disc_last, 6'h02);
    $display("t_output done");
  endtask
  // read one block of 64 words with stalls
  task automatic rd_block();
    host.select(12'ha03, ok);
    host.go();
    for (int i = 0; i < 64; i++) host.pop(blk[i]);
    host.disc();
  endtask
  task automatic t_input();
    take <= 1'b0;
    ilk[6:5] <= 2'h3;
    for (int b = 0; b < 2; b++) begin
      host.select(12'ha01, ok);
      host.go();
      host.push(12'h841 + 12'(b));
      host.disc();
    end
    rx(6'h05, 8'ha5);
    rx(6'h06, 8'h11);
    rx(6'h06, 8'h3c);
    rd_block();
    chk(blk[5], 12'haa5);
    chk(blk[6], 12'he3c);
    chk(blk[0] & 12'h100, 12'h100);
    take <= 1'b1;
    rd_block();
    chk(blk[6] & 12'h400, 12'h000);
    chk(blk[0] & 12'h100, 12'h000);
    $display("t_input done");
  endtask
  task automatic t_status();
    host.select(12'ha02, ok);
    host.go();
    host.pop(w);
    host.disc();
    chk(w & 12'h004, 12'h004);
    for (int i = 0; i < 400 && st[1] !== 1'b1; i++) @(posedge clk);
    chk(st[1], 1'b1);
    for (int i = 0; i < 800 && st[0] !== 1'b1; i++) @(posedge clk);
    chk(st[0], 1'b1);
    host.select(12'ha03, ok);
    repeat (2) @(posedge clk);
    chk(st[0], 1'b0);
    host.disc();
    $display("t_status done");
  endtask
  task automatic t_mclear();
    host.select(12'ha01, ok);
    mclr <= 1'b1;
    repeat (8) @(posedge clk);
    mclr <= 1'b0;
    repeat (2) @(posedge clk);
    chk(mode, 3'h0);
    chk(empty, 1'b1);
    $display("t_mclear done");
  endtask
  // switch settings: equipment, duplex, baud, stop length and service base
  task automatic t_config();
    int n;
    eq <= 3'h2;
    mdup <= 1'b0;
    mbaud <= 1'b0;
    stop1 <= 1'b0;
    svc <= 1'b0;
    repeat (4) @(posedge clk);
    chk({txfd, txb, txs}, 3'h1);
    host.select(12'ha03, ok);
    chk(ok, 1'b0);
    mdup <= 1'b1;
    ffs <= 6'h20;
    mbaud <= 1'b1;
    f110 <= 6'h30;
    stop1 <= 1'b1;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 64; k++) begin
      @(posedge clk);
      chk(txfd, txt >= 6'h20);
      chk(txb, txt >= 6'h30);
      chk(txs, txt >= 6'h30);
    end
    host.select(12'h403, ok);
    chk(ok, 1'b1);
    host.disc();
    n = 0;
    while (st[1] !== 1'b1 && n < 1100) begin
      @(posedge clk);
      n++;
    end
    host.select(12'h403, ok);
    host.disc();
    n = 3;
    while (st[1] !== 1'b1 && n < 1100) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n), 16'(CHAR110));
    $display("t_config done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_select();
    t_output();
    t_input();
    t_status();
    t_mclear();
    t_config();
    stop_test();
  end
endmodule
`default_nettype wire
